// *** src/analog_param_decoder.sv ***
// Purpose: parameter record store, decoder and result scaling for an 8-channel analog input
// Assumes: controller writes bytes on a strobe port; cpu_run high while the controller runs
// Notes: writes land in a staging area and are applied to the active area on stop to run; set 1 also on commit while running
//
// Summary of operation
// - 16-byte area in record sets 0 and 1, loaded on transfer.
// - runtime writes only reach set 1; set 0 only at startup.
// - two-channel build uses pair 0 (channels 0 and 1) only, ignores other pair mode, diagnosis and wire-break fields; their frequency bits still reach pair_freq.
// - set 0 byte 0 bits 3..0 group diagnosis per pair, reset 00h.
// - set 0 byte 1 bits 3..0 wire-break test per pair, reset 00h.
// - set 1 byte 0 bit 6 diagnostic, bit 7 process interrupt enable.
// - set 1 byte 1 two-bit frequency per pair, reset AAh.
// - set 1 bytes 2..5 pair mode: range low, type high, reset 19h.
// - set 1 bytes 6..13 channel 0 and 2 limits, 7FFFh and 8000h.
// - all-zero mode byte switches the pair off.
// - voltage type range codes select bipolar spans or unipolar 1..5V.
// - bipolar spans: nominal +-27648, ends 32511 and -32512.
// - unipolar spans: nominal 0..27648, ends 32511 and -4864.
// - four-wire current: three bipolar codes, 0..20mA and 4..20mA.
// - two-wire current: only range code 0011b, unipolar 4..20mA.
// - resistance codes 2, 4, 6: 0..27648, never negative.
// - stored parameters applied when the controller goes from stop to run.
// - power-on default: +-10V, 50Hz, diagnostics off on every pair.
// - beyond overdrive end gives 7FFFh, below underdrive end 8000h.
// - resolution 14, 12 or 9 bits by frequency, low bits zero.
`timescale 1ns/1ps
module analog_param_decoder
  import analog_param_pkg::*;
#(
  parameter int PAIRS = 4,
  parameter bit TWO_CHANNEL = 1'b0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cpu_run,
  input wire logic prm_wr,
  input wire logic prm_set,
  input wire logic [3:0] prm_idx,
  input wire logic [7:0] prm_data,
  input wire logic prm_commit,
  input wire logic rd_set,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data,
  output logic wr_refused,
  input wire logic conv_valid,
  input wire logic [2:0] conv_chan,
  input wire logic signed [17:0] conv_raw,
  output logic res_valid,
  output logic [2:0] res_chan,
  output logic [15:0] res_value,
  output logic limit_hit,
  output logic [PAIRS-1:0] pair_active,
  output logic [2*PAIRS-1:0] pair_freq,
  output logic [PAIRS-1:0] group_diag_en,
  output logic [PAIRS-1:0] wire_break_en,
  output logic diag_irq_en,
  output logic proc_irq_en
);

  // ------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------
  decoder_state_type q;
  decoder_state_type d;
  span_kind_type pair_kind [PAIRS];
  span_kind_type used_kind [PAIRS];
  logic [PAIRS-1:0] pair_used;
  logic sc_valid;
  logic [2:0] sc_chan;
  logic [15:0] sc_value;
  logic [1:0] conv_pair;
  logic [3:0] rd_addr;
  logic rd_ok;
  logic signed [15:0] up_lim;
  logic signed [15:0] lo_lim;

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++)
    begin : gen_pair
      mode_decoder u_mode (
        .mode_byte(q.active[AREA_MODE + 4'(g)]),
        .kind(pair_kind[g])
      );
      // other pairs ignored in two-channel build
      assign pair_used[g] = !TWO_CHANNEL || (g == 0);
      assign used_kind[g] = pair_used[g] ? pair_kind[g] : SPAN_OFF;
      assign pair_active[g] = (used_kind[g] != SPAN_OFF);
      assign pair_freq[2*g +: 2] = q.active[AREA_FREQ][2*g +: 2];
      assign group_diag_en[g] = pair_used[g] && q.active[AREA_DIAG][g];
      assign wire_break_en[g] = pair_used[g] && q.active[AREA_WBRK][g];
    end
  endgenerate

  assign diag_irq_en = q.active[AREA_IRQ][IRQ_DIAG_BIT];
  assign proc_irq_en = q.active[AREA_IRQ][IRQ_PROC_BIT];

  // ------------------------------------------------------------
  // scaling path
  // ------------------------------------------------------------
  assign conv_pair = conv_chan[2:1];

  value_scaler u_scaler (
    .clk(clk),
    .nrst(nrst),
    .in_valid(conv_valid),
    .in_chan(conv_chan),
    .in_raw(conv_raw),
    .in_kind(used_kind[conv_pair]),
    .in_freq(q.active[AREA_FREQ][{conv_pair, 1'b0} +: 2]),
    .out_valid(sc_valid),
    .out_chan(sc_chan),
    .out_value(sc_value)
  );

  always_comb
  begin
    if (sc_chan == 3'h2)
    begin
      up_lim = {q.active[AREA_CH2_UP], q.active[AREA_CH2_UP + 4'h1]};
      lo_lim = {q.active[AREA_CH2_LO], q.active[AREA_CH2_LO + 4'h1]};
    end
    else
    begin
      up_lim = {q.active[AREA_CH0_UP], q.active[AREA_CH0_UP + 4'h1]};
      lo_lim = {q.active[AREA_CH0_LO], q.active[AREA_CH0_LO + 4'h1]};
    end
  end

  // ------------------------------------------------------------
  // record read address
  // ------------------------------------------------------------
  always_comb
  begin
    if (rd_set)
    begin
      rd_addr = 4'(SET1_BASE + rd_idx);
      rd_ok = (rd_idx < SET1_BYTES);
    end
    else
    begin
      rd_addr = rd_idx;
      rd_ok = (rd_idx < SET0_BYTES);
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.run = cpu_run;
    d.refused = 1'b0;
    d.limit_hit = 1'b0;
    if (prm_wr)
    begin
      if (!prm_set && !cpu_run && prm_idx < SET0_BYTES)
      begin
        d.stage[prm_idx] = prm_data;
      end
      else if (prm_set && prm_idx < SET1_BYTES)
      begin
        d.stage[4'(SET1_BASE + prm_idx)] = prm_data;
      end
      else
      begin
        d.refused = 1'b1;
      end
    end
    // apply all on stop to run
    if (cpu_run && !q.run)
    begin
      d.active = d.stage;
    end
    // runtime commit touches set 1 only
    else if (prm_commit && cpu_run)
    begin
      for (int i = SET1_BASE; i < AREA_BYTES; i++)
      begin
        d.active[i] = d.stage[i];
      end
    end
    d.rd_data = rd_ok ? q.active[rd_addr] : 8'h00;
    d.res_valid = sc_valid;
    d.res_chan = sc_chan;
    d.res_value = sc_value;
    // process limit check channels 0 and 2
    if (sc_valid && proc_irq_en && (sc_chan == 3'h0 || sc_chan == 3'h2))
    begin
      d.limit_hit = ($signed(sc_value) > up_lim) || ($signed(sc_value) < lo_lim);
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.stage <= AREA_RESET;
      q.active <= AREA_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign wr_refused = q.refused;
  assign res_valid = q.res_valid;
  assign res_chan = q.res_chan;
  assign res_value = q.res_value;
  assign limit_hit = q.limit_hit;

endmodule

// *** src/analog_param_pkg.sv ***
// Purpose: shared constants and types for the analog input parameter decoder
// Assumes: 16-byte parameter area, record set 0 at area 0..1, record set 1 at area 2..15
// Notes: limit words are stored high byte first
package analog_param_pkg;

  // ------------------------------------------------------------
  // parameter area layout
  // ------------------------------------------------------------
  localparam int AREA_BYTES = 16;
  localparam logic [3:0] SET0_BYTES = 4'h2;
  localparam logic [3:0] SET1_BYTES = 4'hE;
  localparam logic [3:0] SET1_BASE = 4'h2;
  localparam logic [3:0] AREA_DIAG = 4'h0;
  localparam logic [3:0] AREA_WBRK = 4'h1;
  localparam logic [3:0] AREA_IRQ = 4'h2;
  localparam logic [3:0] AREA_FREQ = 4'h3;
  localparam logic [3:0] AREA_MODE = 4'h4;
  localparam logic [3:0] AREA_CH0_UP = 4'h8;
  localparam logic [3:0] AREA_CH0_LO = 4'hA;
  localparam logic [3:0] AREA_CH2_UP = 4'hC;
  localparam logic [3:0] AREA_CH2_LO = 4'hE;
  localparam int IRQ_DIAG_BIT = 6;
  localparam int IRQ_PROC_BIT = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic [7:0] WBRK_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'hAA;
  localparam logic [7:0] MODE_RESET = 8'h19;
  localparam logic [15:0] UPPER_RESET = 16'h7FFF;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [15:0][7:0] AREA_RESET = {LOWER_RESET[7:0], LOWER_RESET[15:8],
    UPPER_RESET[7:0], UPPER_RESET[15:8], LOWER_RESET[7:0], LOWER_RESET[15:8],
    UPPER_RESET[7:0], UPPER_RESET[15:8], MODE_RESET, MODE_RESET, MODE_RESET, MODE_RESET,
    FREQ_RESET, IRQ_RESET, WBRK_RESET, DIAG_RESET};

  // ------------------------------------------------------------
  // measuring type and range codes
  // ------------------------------------------------------------
  localparam logic [3:0] TYPE_VOLT = 4'h1;
  localparam logic [3:0] TYPE_CUR4 = 4'h2;
  localparam logic [3:0] TYPE_CUR2 = 4'h3;
  localparam logic [3:0] TYPE_RES4 = 4'h4;
  localparam logic [3:0] RNG_0 = 4'h0;
  localparam logic [3:0] RNG_1 = 4'h1;
  localparam logic [3:0] RNG_2 = 4'h2;
  localparam logic [3:0] RNG_3 = 4'h3;
  localparam logic [3:0] RNG_4 = 4'h4;
  localparam logic [3:0] RNG_5 = 4'h5;
  localparam logic [3:0] RNG_6 = 4'h6;
  localparam logic [3:0] RNG_7 = 4'h7;
  localparam logic [3:0] RNG_9 = 4'h9;

  typedef enum logic [1:0] {SPAN_OFF, SPAN_BIPOLAR, SPAN_UNIPOLAR, SPAN_RESIST} span_kind_type;

  // ------------------------------------------------------------
  // scaling limits and resolution
  // ------------------------------------------------------------
  localparam logic signed [17:0] NOMINAL_END = 18'sh06C00;
  localparam logic signed [17:0] OVER_END = 18'sh07EFF;
  localparam logic signed [17:0] UNDER_END_BIP = 18'sh38100;
  localparam logic signed [17:0] UNDER_END_UNI = 18'sh3ED00;
  localparam logic signed [17:0] ZERO_VALUE = 18'sh00000;
  localparam logic [15:0] CLAMP_HIGH = 16'h7FFF;
  localparam logic [15:0] CLAMP_LOW = 16'h8000;
  localparam logic [1:0] FREQ_400HZ = 2'h0;
  localparam logic [1:0] FREQ_60HZ = 2'h1;
  localparam logic [1:0] FREQ_50HZ = 2'h2;
  localparam logic [1:0] FREQ_10HZ = 2'h3;
  localparam logic [15:0] MASK_14BIT = 16'hFFFE;
  localparam logic [15:0] MASK_12BIT = 16'hFFF8;
  localparam logic [15:0] MASK_9BIT = 16'hFFC0;

  // resolution mask per interference setting
  function automatic logic [15:0] res_mask(input logic [1:0] freq);
    logic [15:0] m;
    m = MASK_12BIT;
    case (freq)
      FREQ_10HZ: m = MASK_14BIT;
      FREQ_400HZ: m = MASK_9BIT;
      default: m = MASK_12BIT;
    endcase
    return m;
  endfunction

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [15:0] value;
  } scaler_state_type;

  typedef struct packed {
    logic [15:0][7:0] stage;
    logic [15:0][7:0] active;
    logic run;
    logic [7:0] rd_data;
    logic refused;
    logic res_valid;
    logic [2:0] res_chan;
    logic [15:0] res_value;
    logic limit_hit;
  } decoder_state_type;

endpackage

// *** src/mode_decoder.sv ***
// Purpose: decode one channel-pair mode byte into a scaling kind
// Assumes: type in bits 7..4, range in bits 3..0
// Notes: purely combinational
`timescale 1ns/1ps
module mode_decoder
  import analog_param_pkg::*;
(
  input wire logic [7:0] mode_byte,
  output span_kind_type kind
);

  logic [3:0] mtype;
  logic [3:0] mrange;

  assign mtype = mode_byte[7:4];
  assign mrange = mode_byte[3:0];

  always_comb
  begin
    kind = SPAN_OFF;
    case (mtype)
      TYPE_VOLT:
      begin
        case (mrange)
          RNG_1, RNG_2, RNG_3, RNG_4, RNG_5, RNG_6, RNG_9: kind = SPAN_BIPOLAR;
          RNG_7: kind = SPAN_UNIPOLAR;
          default: kind = SPAN_OFF;
        endcase
      end
      TYPE_CUR4:
      begin
        case (mrange)
          RNG_0, RNG_1, RNG_4: kind = SPAN_BIPOLAR;
          RNG_2, RNG_3: kind = SPAN_UNIPOLAR;
          default: kind = SPAN_OFF;
        endcase
      end
      TYPE_CUR2:
      begin
        kind = (mrange == RNG_3) ? SPAN_UNIPOLAR : SPAN_OFF;
      end
      TYPE_RES4:
      begin
        case (mrange)
          RNG_2, RNG_4, RNG_6: kind = SPAN_RESIST;
          default: kind = SPAN_OFF;
        endcase
      end
      default: kind = SPAN_OFF;
    endcase
  end

endmodule

// *** src/value_scaler.sv ***
// Purpose: clamp and resolution-mask one converted value
// Assumes: raw value already in nominal units (27648 = span end)
// Notes: one cycle latency; inactive pairs produce no result
`timescale 1ns/1ps
module value_scaler
  import analog_param_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [2:0] in_chan,
  input wire logic signed [17:0] in_raw,
  input span_kind_type in_kind,
  input wire logic [1:0] in_freq,
  output logic out_valid,
  output logic [2:0] out_chan,
  output logic [15:0] out_value
);

  scaler_state_type q;
  scaler_state_type d;
  logic signed [17:0] under_end;
  logic signed [17:0] val;

  always_comb
  begin
    d = q;
    d.valid = in_valid && (in_kind != SPAN_OFF);
    d.chan = in_chan;
    val = in_raw;
    if (in_kind == SPAN_RESIST && in_raw < ZERO_VALUE)
    begin
      val = ZERO_VALUE;
    end
    under_end = (in_kind == SPAN_BIPOLAR) ? UNDER_END_BIP : UNDER_END_UNI;
    if (val > OVER_END)
    begin
      d.value = CLAMP_HIGH;
    end
    else if (val < under_end)
    begin
      d.value = CLAMP_LOW;
    end
    else
    begin
      d.value = val[15:0] & res_mask(in_freq);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign out_valid = q.valid;
  assign out_chan = q.chan;
  assign out_value = q.value;

endmodule

// *** verif/analog_param_assertions.sv ***
// Purpose: port-level checks for the parameter decoder
// Assumes: one clock, nrst asynchronous active low
// Notes: bound into every analog_param_decoder
`timescale 1ns/1ps
module analog_param_checker
  import analog_param_pkg::*;
#(
  parameter int PAIRS = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cpu_run,
  input wire logic prm_wr,
  input wire logic prm_set,
  input wire logic [3:0] prm_idx,
  input wire logic prm_commit,
  input wire logic rd_set,
  input wire logic [3:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic wr_refused,
  input wire logic conv_valid,
  input wire logic [2:0] conv_chan,
  input wire logic signed [17:0] conv_raw,
  input wire logic res_valid,
  input wire logic [2:0] res_chan,
  input wire logic [15:0] res_value,
  input wire logic limit_hit,
  input wire logic [PAIRS-1:0] pair_active,
  input wire logic [2*PAIRS-1:0] pair_freq,
  input wire logic [PAIRS-1:0] group_diag_en,
  input wire logic [PAIRS-1:0] wire_break_en,
  input wire logic diag_irq_en,
  input wire logic proc_irq_en
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  res_timing_a: assert property (res_valid |-> $past(conv_valid, 2) && res_chan == $past(conv_chan, 2))
    else $error("result without matching conversion");
  off_pair_a: assert property (conv_valid && !pair_active[conv_chan[2:1]] |-> ##2 !res_valid)
    else $error("result from inactive pair");
  high_clamp_a: assert property (conv_valid && pair_active[conv_chan[2:1]] && conv_raw > OVER_END
    |-> ##2 res_value == 16'h7FFF)
    else $error("overdrive not clamped");
  resolution_a: assert property (res_valid && res_value != 16'h7FFF |-> res_value[0] == 1'b0)
    else $error("low result bit not zero");
  limit_cause_a: assert property (limit_hit |-> res_valid && proc_irq_en && res_chan[0] == 1'b0
    && res_chan[2] == 1'b0)
    else $error("limit flag without cause");
  set0_refuse_a: assert property (prm_wr && !prm_set && cpu_run |=> wr_refused)
    else $error("runtime set 0 write not refused");
  idx_refuse_a: assert property (prm_wr && prm_set && prm_idx > 4'hD |=> wr_refused)
    else $error("out of area write not refused");
  bad_read_a: assert property ((rd_set ? rd_idx > 4'hD : rd_idx > 4'h1) |=> rd_data == 8'h00)
    else $error("invalid read not zero");
  set0_hold_a: assert property (!$rose(cpu_run) |=> $stable(group_diag_en) && $stable(wire_break_en))
    else $error("set 0 outputs changed in run");
  set1_hold_a: assert property (!$rose(cpu_run) && !(prm_commit && cpu_run)
    |=> $stable(pair_freq) && $stable(pair_active) && $stable({diag_irq_en, proc_irq_en}))
    else $error("set 1 outputs changed without apply");
endmodule

bind analog_param_decoder analog_param_checker #(.PAIRS(PAIRS)) analog_param_checker_inst (
  .clk, .nrst, .cpu_run, .prm_wr, .prm_set, .prm_idx, .prm_commit, .rd_set, .rd_idx, .rd_data, .wr_refused,
  .conv_valid, .conv_chan, .conv_raw, .res_valid, .res_chan, .res_value, .limit_hit, .pair_active,
  .pair_freq, .group_diag_en, .wire_break_en, .diag_irq_en, .proc_irq_en);

// *** verif/ctrl_model.sv ***
// Purpose: controller side writing parameter records
// Assumes: requests change 1ns after a rising edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
module ctrl_model
(
  input wire logic clk,
  output logic cpu_run,
  output logic prm_wr,
  output logic prm_set,
  output logic [3:0] prm_idx,
  output logic [7:0] prm_data,
  output logic prm_commit
);
  initial
  begin
    cpu_run = 1'b0;
    prm_wr = 1'b0;
    prm_set = 1'b0;
    prm_idx = 4'h0;
    prm_data = 8'h00;
    prm_commit = 1'b0;
  end
  task automatic wr(input logic s, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    #1;
    prm_wr = 1'b1;
    prm_set = s;
    prm_idx = i;
    prm_data = d;
    @(posedge clk);
    #1;
    prm_wr = 1'b0;
    prm_idx = ~i;
    prm_data = ~d;
  endtask
  task automatic go_run();
    @(posedge clk);
    #1;
    cpu_run = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic commit();
    @(posedge clk);
    #1;
    prm_commit = 1'b1;
    @(posedge clk);
    #1;
    prm_commit = 1'b0;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the parameter decoder
// Assumes: 40 MHz clock, inputs change 1ns after edges
// Notes: limit words written high byte first
`timescale 1ns/1ps
module tb_top
  import analog_param_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cpu_run, prm_wr, prm_set, prm_commit, rd_set, wr_refused, conv_valid;
  logic res_valid, limit_hit, diag_irq_en, proc_irq_en;
  logic [3:0] prm_idx, rd_idx, pair_active, group_diag_en, wire_break_en;
  logic [7:0] prm_data, rd_data, pair_freq;
  logic [2:0] conv_chan, res_chan;
  logic signed [17:0] conv_raw;
  logic [15:0] res_value;
  logic [3:0] tc_active, tc_diag;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] rst_area [16] = '{8'h00, 8'h00, 8'h00, 8'hAA, 8'h19, 8'h19, 8'h19, 8'h19,
    8'h7F, 8'hFF, 8'h80, 8'h00, 8'h7F, 8'hFF, 8'h80, 8'h00};
  logic [12:0] wl [12] = '{13'h0005, 13'h010A, 13'h10C0, 13'h111B, 13'h1219, 13'h1300,
    13'h1417, 13'h1546, 13'h1610, 13'h1700, 13'h18F0, 13'h1900};
  logic [2:0] tc [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h4, 3'h6, 3'h6, 3'h6};
  logic [17:0] tr [11] = '{18'h09C40, 18'h363C0, 18'h38100, 18'h07EFF, 18'h0000D, 18'h00064,
    18'h3ECFF, 18'h3ED00, 18'h3FF9C, 18'h003E8, 18'h07F00};
  logic [15:0] te [11] = '{16'h7FFF, 16'h8000, 16'h8100, 16'h7EFE, 16'h000C, 16'h0000,
    16'h8000, 16'hED00, 16'h0000, 16'h03C0, 16'h7FFF};
  logic [10:0] tv = 11'h7DF;
  logic [10:0] tl = 11'h00F;
  logic [7:0] mc [23] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h19, 8'h17, 8'h20, 8'h21,
    8'h24, 8'h22, 8'h23, 8'h33, 8'h42, 8'h44, 8'h46, 8'h18, 8'h10, 8'h34, 8'h41, 8'h50, 8'h00};
  logic [22:0] ma = 23'h01FFFF;

  always #12.5 clk = ~clk;

  ctrl_model ctrl_model_inst (.clk(clk), .cpu_run(cpu_run), .prm_wr(prm_wr), .prm_set(prm_set),
    .prm_idx(prm_idx), .prm_data(prm_data), .prm_commit(prm_commit));

  analog_param_decoder analog_param_decoder_inst (.clk(clk), .nrst(nrst), .cpu_run(cpu_run),
    .prm_wr(prm_wr), .prm_set(prm_set), .prm_idx(prm_idx), .prm_data(prm_data), .prm_commit(prm_commit),
    .rd_set(rd_set), .rd_idx(rd_idx), .rd_data(rd_data), .wr_refused(wr_refused), .conv_valid(conv_valid),
    .conv_chan(conv_chan), .conv_raw(conv_raw), .res_valid(res_valid), .res_chan(res_chan),
    .res_value(res_value), .limit_hit(limit_hit), .pair_active(pair_active), .pair_freq(pair_freq),
    .group_diag_en(group_diag_en), .wire_break_en(wire_break_en), .diag_irq_en(diag_irq_en),
    .proc_irq_en(proc_irq_en));

  // two-channel build on the same inputs
  analog_param_decoder #(.PAIRS(4), .TWO_CHANNEL(1'b1)) analog_param_decoder_two_inst (.clk(clk), .nrst(nrst),
    .cpu_run(cpu_run), .prm_wr(prm_wr), .prm_set(prm_set), .prm_idx(prm_idx), .prm_data(prm_data),
    .prm_commit(prm_commit), .rd_set(rd_set), .rd_idx(rd_idx), .rd_data(), .wr_refused(),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_raw(conv_raw), .res_valid(), .res_chan(),
    .res_value(), .limit_hit(), .pair_active(tc_active), .pair_freq(), .group_diag_en(tc_diag),
    .wire_break_en(), .diag_irq_en(), .proc_irq_en());

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic s, input logic [3:0] i, input logic [7:0] e);
    @(posedge clk);
    #1;
    rd_set = s;
    rd_idx = i;
    @(posedge clk);
    #1;
    chk(16'(rd_data), 16'(e));
  endtask

  task automatic cv(input logic [2:0] c, input logic [17:0] r, input logic v, input logic [15:0] e,
    input logic l);
    logic got;
    got = 1'b0;
    @(posedge clk);
    #1;
    conv_valid = 1'b1;
    conv_chan = c;
    conv_raw = r;
    @(posedge clk);
    #1;
    conv_valid = 1'b0;
    conv_raw = ~r;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      if (res_valid === 1'b1)
      begin
        got = 1'b1;
        chk(16'(res_chan), 16'(c));
        chk(res_value, e);
        chk(16'(limit_hit), 16'(l));
      end
    end
    chk(16'(got), 16'(v));
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    rd_set = 1'b0;
    rd_idx = 4'h0;
    conv_valid = 1'b0;
    conv_chan = 3'h0;
    conv_raw = 18'h00000;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 16; i++)
      rd(i > 1, (i > 1) ? 4'(i - 2) : 4'(i), rst_area[i]);
    rd(1'b0, 4'h2, 8'h00);
    rd(1'b1, 4'hE, 8'h00);
    chk({4'h0, pair_active, pair_freq}, 16'h0FAA);
    chk({8'h00, group_diag_en, wire_break_en}, 16'h0000);
    for (int i = 0; i < 12; i++)
      ctrl_model_inst.wr(wl[i][12], wl[i][11:8], wl[i][7:0]);
    chk(16'(pair_freq), 16'h00AA);
    ctrl_model_inst.go_run();
    chk({8'h00, tc_active, tc_diag}, 16'h0011);
    chk({8'h00, group_diag_en, wire_break_en}, 16'h005A);
    chk({14'h0000, diag_irq_en, proc_irq_en}, 16'h0003);
    chk({4'h0, pair_active, pair_freq}, 16'h0D1B);
    rd(1'b1, 4'h6, 8'h10);
    rd(1'b1, 4'h4, 8'h17);
    for (int i = 0; i < 11; i++)
      cv(tc[i], tr[i], tv[i], te[i], tl[i]);
    ctrl_model_inst.wr(1'b0, 4'h0, 8'h0F);
    chk(16'(wr_refused), 16'h0001);
    ctrl_model_inst.wr(1'b1, 4'hE, 8'h55);
    chk(16'(wr_refused), 16'h0001);
    ctrl_model_inst.wr(1'b1, 4'h3, 8'h24);
    ctrl_model_inst.wr(1'b1, 4'h2, 8'h18);
    ctrl_model_inst.commit();
    chk({12'h000, pair_active}, 16'h000E);
    chk({12'h000, group_diag_en}, 16'h0005);
    cv(3'h0, 18'h0000D, 1'b0, 16'h0000, 1'b0);
    cv(3'h2, 18'h0000D, 1'b1, 16'h0008, 1'b0);
    for (int i = 0; i < 23; i++)
    begin
      ctrl_model_inst.wr(1'b1, 4'h5, mc[i]);
      ctrl_model_inst.commit();
      chk(16'(pair_active[3]), 16'(ma[i]));
    end
    wrap_up();
  end
endmodule
